/* mmr_pkg.sv */
// Contract
// RULE1 - Immediate load writes accumulator, flags untouched
// RULE2 - Register copy goes to accumulator or itself
// RULE3 - Register copy sets zero flag from value
// RULE4 - Interrupt return pops PC, enables interrupts
// RULE5 - Literal return loads accumulator, pops PC
// RULE6 - Rotate left shifts bits, carry in/out
// RULE7 - Rotate result to chosen destination, carry only
// RULE8 - Idle changes nothing, PC advances one
`default_nettype none
package mmr_pkg;
   localparam int DATA_W = 8;
   localparam int ADDR_W = 7;
   localparam int PC_W = 11;
   localparam int STACK_DEPTH = 8;
   localparam int SP_W = 3;
   localparam logic [DATA_W-1:0] WORK_RST = 8'h00;
   localparam logic [PC_W-1:0] PC_RST = 11'h000;
   localparam logic [SP_W-1:0] SP_RST = 3'h0;
   localparam int ROT_MSB = 7;
   localparam int CYC_ONE = 1;
   localparam int CYC_TWO = 2;

   typedef enum logic [2:0] {
      idle_op,
      load_immediate_op,
      copy_register_op,
      return_interrupt_op,
      return_literal_op,
      rotate_left_carry_op
   } mmr_op_e;

   // One instruction as presented by fetch
   typedef struct packed {
      mmr_op_e op;
      logic dest_reg;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] imm;
   } mmr_instr_s;

   // Data memory write request
   typedef struct packed {
      logic en;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } mmr_wr_s;

   // Rotate left through carry: {carry_out, result}
   function automatic logic [DATA_W:0] mmr_rotl(input logic [DATA_W-1:0] v, input logic c);
      mmr_rotl = {v[ROT_MSB], v[ROT_MSB-1:0], c};
   endfunction
endpackage
`default_nettype wire

/* mmr_stack.sv */
`default_nettype none
// Return address stack, flip-flop storage indexed by pointer
module mmr_stack
   import mmr_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic nrst_i,
   input wire logic push_i,
   input wire logic [PC_W-1:0] push_data_i,
   input wire logic pop_i,
   output logic [PC_W-1:0] top_o,
   output logic [SP_W-1:0] sp_o
);
   logic [PC_W-1:0] mem [STACK_DEPTH];
   logic [SP_W-1:0] sp;

   // Pointer names next free level; top lives one below
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         sp <= SP_RST;
      end else if (push_i) begin
         sp <= sp + 3'h1;
      end else if (pop_i) begin
         sp <= sp - 3'h1;
      end
   end

   // Storage has no reset; contents are don't-care until pushed
   always_ff @(posedge sys_clk_i) begin
      if (push_i) begin
         mem[sp] <= push_data_i;
      end
   end

   assign top_o = mem[sp - 3'h1];
   assign sp_o = sp;
endmodule
`default_nettype wire

/* mmr_core.sv */
`default_nettype none
// Executes the move, return and rotate group
module mmr_core
   import mmr_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic nrst_i,
   input wire logic instr_valid_i,
   input wire mmr_instr_s instr_i,
   input wire logic [DATA_W-1:0] reg_rdata_i,
   input wire logic call_push_i,
   input wire logic int_ack_i,
   output logic [ADDR_W-1:0] reg_addr_o,
   output mmr_wr_s reg_wr_o,
   output logic [DATA_W-1:0] work_register_o,
   output logic [PC_W-1:0] pc_o,
   output logic carry_o,
   output logic zero_o,
   output logic global_interrupt_enable_o,
   output logic busy_o,
   output logic [SP_W-1:0] sp_o
);
   typedef enum logic {st_exec, st_pop} mmr_state_e;

   // Architectural state and stack handshake
   mmr_state_e state;
   logic [DATA_W-1:0] work_register;
   logic [PC_W-1:0] pc;
   logic carry;
   logic zero;
   logic global_interrupt_enable;
   logic [PC_W-1:0] stack_top;
   logic [SP_W-1:0] stack_sp;
   logic stack_pop;
   logic [DATA_W:0] rot;
   logic take;

   // Only accept new work in the execute state
   assign take = instr_valid_i && (state == st_exec);
   assign reg_addr_o = instr_i.addr;
   assign rot = mmr_rotl(reg_rdata_i, carry); // [RULE6]
   assign stack_pop = take && (instr_i.op == return_interrupt_op || instr_i.op == return_literal_op); // [RULE4] [RULE5]

   mmr_stack mmr_stack_inst (
      .sys_clk_i(sys_clk_i),
      .nrst_i(nrst_i),
      .push_i(call_push_i),
      .push_data_i(pc + 11'h001),
      .pop_i(stack_pop),
      .top_o(stack_top),
      .sp_o(stack_sp)
   );

   // Returns spend a second cycle; the pipeline stalls through it
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state <= st_exec;
      end else if (stack_pop) begin
         state <= st_pop; // [RULE4] [RULE5]
      end else begin
         state <= st_exec;
      end
   end

   // Busy marks the bubble cycle of a return
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         busy_o <= 1'b0;
      end else begin
         busy_o <= stack_pop;
      end
   end

   // Program counter
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         pc <= PC_RST;
      end else if (stack_pop) begin
         pc <= stack_top; // [RULE4] [RULE5]
      end else if (take) begin
         pc <= pc + 11'h001; // [RULE8]
      end
   end

   // Accumulator
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         work_register <= WORK_RST;
      end else if (take) begin
         case (instr_i.op)
            load_immediate_op: work_register <= instr_i.imm; // [RULE1]
            return_literal_op: work_register <= instr_i.imm; // [RULE5]
            copy_register_op: if (!instr_i.dest_reg) work_register <= reg_rdata_i; // [RULE2]
            rotate_left_carry_op: if (!instr_i.dest_reg) work_register <= rot[DATA_W-1:0]; // [RULE7]
            default: work_register <= work_register; // [RULE8]
         endcase
      end
   end

   // Data memory write-back, a one-cycle request
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         reg_wr_o <= '0;
      end else begin
         reg_wr_o.en <= take && instr_i.dest_reg &&
            (instr_i.op == copy_register_op || instr_i.op == rotate_left_carry_op); // [RULE2] [RULE7]
         reg_wr_o.addr <= instr_i.addr;
         reg_wr_o.data <= (instr_i.op == rotate_left_carry_op) ? rot[DATA_W-1:0] : reg_rdata_i;
      end
   end

   // Only copy touches zero; only rotate touches carry
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         zero <= 1'b0;
      end else if (take && instr_i.op == copy_register_op) begin
         zero <= (reg_rdata_i == 8'h00); // [RULE3]
      end
   end

   // Carry takes the bit rotated out of the top
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         carry <= 1'b0;
      end else if (take && instr_i.op == rotate_left_carry_op) begin
         carry <= rot[DATA_W]; // [RULE6] [RULE7]
      end
   end

   // Interrupt acceptance clears enable; interrupt return sets it, and wins
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         global_interrupt_enable <= 1'b0;
      end else if (take && instr_i.op == return_interrupt_op) begin
         global_interrupt_enable <= 1'b1; // [RULE4]
      end else if (int_ack_i) begin
         global_interrupt_enable <= 1'b0;
      end
   end

   // Outputs are plain copies of the state flops
   assign work_register_o = work_register;
   assign pc_o = pc;
   assign carry_o = carry;
   assign zero_o = zero;
   assign global_interrupt_enable_o = global_interrupt_enable;
   assign sp_o = stack_sp;

   sequence s_ret_taken;
      take && (instr_i.op == return_interrupt_op || instr_i.op == return_literal_op);
   endsequence
   sequence s_ret_done;
      busy_o && state == st_pop ##1 !busy_o;
   endsequence


   // Return timing and per-op result checks
   chk_ret_two_cycles: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // [RULE4]
      s_ret_taken |=> s_ret_done) else $error("return not two cycles");
   chk_reti_gie: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // [RULE4]
      take && instr_i.op == return_interrupt_op |=> global_interrupt_enable) else $error("gie not set");
   chk_ret_pc: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // [RULE5]
      s_ret_taken |=> pc == $past(stack_top) && stack_sp == $past(stack_sp) - 3'h1) else $error("bad return");
   chk_load_imm: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // [RULE1]
      take && instr_i.op == load_immediate_op |=> work_register == $past(instr_i.imm) && $stable(carry)
      && $stable(zero)) else $error("bad load");
   chk_copy_zero: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // [RULE3]
      take && instr_i.op == copy_register_op |=> zero == ($past(reg_rdata_i) == 8'h00)) else $error("bad zero");
   chk_copy_dest: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // [RULE2]
      take && instr_i.op == copy_register_op && instr_i.dest_reg |=> reg_wr_o.en
      && reg_wr_o.data == $past(reg_rdata_i) && $stable(work_register)) else $error("bad copy");
   chk_rot_value: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // [RULE6]
      take && instr_i.op == rotate_left_carry_op && !instr_i.dest_reg |=>
      work_register == {$past(reg_rdata_i[6:0]), $past(carry)} && carry == $past(reg_rdata_i[7])
      && $stable(zero)) else $error("bad rotate");
   chk_rot_dest: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // [RULE7]
      take && instr_i.op == rotate_left_carry_op && instr_i.dest_reg |=> reg_wr_o.en
      && $stable(work_register)) else $error("bad rotate dest");
   chk_idle_pc: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // [RULE8]
      take && instr_i.op == idle_op |=> pc == $past(pc) + 11'h001 && $stable(work_register)
      && !reg_wr_o.en) else $error("bad idle");

   // Non-return ops step the counter by exactly one
   sequence s_plain_taken;
      take && instr_i.op != return_interrupt_op && instr_i.op != return_literal_op;
   endsequence
   // Rotate accepted, either destination
   sequence s_rot_taken;
      take && instr_i.op == rotate_left_carry_op;
   endsequence

   // Flag isolation and write-back contents
   chk_plain_pc: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // [RULE8]
      s_plain_taken |=> pc == $past(pc) + 11'h001)
      else $error("pc not advanced");
   chk_idle_flags: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // [RULE8]
      take && instr_i.op == idle_op |=> $stable(carry) && $stable(zero))
      else $error("idle changed flags");
   chk_copy_work: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // [RULE2]
      take && instr_i.op == copy_register_op && !instr_i.dest_reg |=>
      work_register == $past(reg_rdata_i) && !reg_wr_o.en && $stable(carry))
      else $error("bad copy to work");
   chk_copy_addr: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // [RULE2]
      take && instr_i.op == copy_register_op && instr_i.dest_reg |=> reg_wr_o.addr == $past(instr_i.addr))
      else $error("bad copy address");
   chk_rot_write: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // [RULE6]
      s_rot_taken ##0 instr_i.dest_reg |=> reg_wr_o.data == {$past(reg_rdata_i[6:0]), $past(carry)}
      && carry == $past(reg_rdata_i[7]) && reg_wr_o.addr == $past(instr_i.addr))
      else $error("bad rotate write");
   chk_rot_zero: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // [RULE7]
      s_rot_taken |=> $stable(zero))
      else $error("rotate changed zero");

   // Returns leave flags alone and stall one cycle
   chk_ret_flags: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // [RULE4]
      take && instr_i.op == return_interrupt_op |=> $stable(work_register) && $stable(carry) && $stable(zero))
      else $error("return changed state");
   chk_retlit_work: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // [RULE5]
      take && instr_i.op == return_literal_op |=> work_register == $past(instr_i.imm) && $stable(carry)
      && $stable(zero)) else $error("bad literal return");
   chk_busy_hold: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // [RULE4]
      state == st_pop |=> $stable(pc) && $stable(work_register) && !reg_wr_o.en)
      else $error("work done in bubble");
endmodule
`default_nettype wire

/* mmr_core_test.sv */
`default_nettype none
module mmr_core_test
   import mmr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk_i = 1'b0;
   logic nrst_i = 1'b0;
   logic instr_valid_i = 1'b0;
   mmr_instr_s instr_i = '0;
   logic [DATA_W-1:0] reg_rdata_i = 8'h00;
   logic call_push_i = 1'b0;
   logic int_ack_i = 1'b0;
   logic [ADDR_W-1:0] reg_addr_o;
   mmr_wr_s reg_wr_o;
   logic [DATA_W-1:0] work_register_o;
   logic [PC_W-1:0] pc_o;
   logic carry_o, zero_o, global_interrupt_enable_o, busy_o;
   logic [SP_W-1:0] sp_o;
   int bad_count = 0;
   int check_count = 0;
   mmr_core mmr_core_inst (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .instr_valid_i(instr_valid_i),
      .instr_i(instr_i), .reg_rdata_i(reg_rdata_i), .call_push_i(call_push_i), .int_ack_i(int_ack_i),
      .reg_addr_o(reg_addr_o), .reg_wr_o(reg_wr_o), .work_register_o(work_register_o), .pc_o(pc_o),
      .carry_o(carry_o), .zero_o(zero_o), .global_interrupt_enable_o(global_interrupt_enable_o),
      .busy_o(busy_o), .sp_o(sp_o));
   // 200 MHz clock
   always #2.5 sys_clk_i = ~sys_clk_i;
   task finish_test;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // Case equality so an unknown never matches
   task cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   // Bubble first, so valid never drops and rises in one time step
   task run(input mmr_op_e op, input logic d, input logic [DATA_W-1:0] imm);
      @(negedge sys_clk_i);
      instr_i = '{op, d, 7'h7f, imm};
      instr_valid_i = 1'b1;
      @(posedge sys_clk_i);
      @(negedge sys_clk_i);
      instr_valid_i = 1'b0;
   endtask
   // Bounded wait: a hung return ends the run
   task wait_idle;
      for (int i = 0; i < 4 && busy_o !== 1'b0; i++) @(negedge sys_clk_i);
      if (busy_o !== 1'b0) begin
         bad_count++;
         $display("FAIL %0t busy stuck", $time);
         finish_test();
      end
   endtask
   task push;
      call_push_i = 1'b1;
      @(posedge sys_clk_i);
      @(negedge sys_clk_i);
      call_push_i = 1'b0;
   endtask
   task t_load;
      logic c, z;
      c = carry_o;
      z = zero_o;
      run(load_immediate_op, 1'b0, 8'h55);
      cmp(work_register_o, 8'h55, "load value");
      cmp({carry_o, zero_o}, {c, z}, "load flags");
   endtask
   task t_copy;
      reg_rdata_i = 8'h00;
      instr_i.addr = 7'h2a;
      #1 cmp(reg_addr_o, 7'h2a, "read addr");
      run(copy_register_op, 1'b0, 8'h00);
      cmp(work_register_o, 8'h00, "copy to work");
      cmp(zero_o, 1'b1, "zero set");
      run(load_immediate_op, 1'b0, 8'h00);
      cmp({work_register_o, zero_o}, {8'h00, 1'b1}, "load keeps zero");
      reg_rdata_i = 8'h3c;
      run(copy_register_op, 1'b1, 8'h00);
      cmp({reg_wr_o.en, reg_wr_o.addr, reg_wr_o.data}, {1'b1, 7'h7f, 8'h3c}, "copy write");
      cmp(work_register_o, 8'h00, "work kept");
      cmp(zero_o, 1'b0, "zero clear");
   endtask
   task t_idle;
      logic [PC_W-1:0] p;
      p = pc_o;
      run(idle_op, 1'b0, 8'h00);
      cmp(pc_o, p + 11'h001, "idle pc");
      cmp({work_register_o, zero_o, sp_o, reg_wr_o.en}, {8'h00, 1'b0, 3'h0, 1'b0}, "idle state");
   endtask
   task t_rot;
      reg_rdata_i = 8'ha5;
      run(rotate_left_carry_op, 1'b1, 8'h00);
      cmp({reg_wr_o.en, reg_wr_o.data, carry_o}, {1'b1, 8'h4a, 1'b1}, "rot to reg");
      run(load_immediate_op, 1'b0, 8'haa);
      cmp({work_register_o, carry_o, zero_o}, {8'haa, 1'b1, 1'b0}, "load keeps carry");
      reg_rdata_i = 8'h01;
      run(rotate_left_carry_op, 1'b0, 8'h00);
      cmp({work_register_o, carry_o, zero_o}, {8'h03, 1'b0, 1'b0}, "rot to work");
   endtask
   task t_ret_lit;
      logic [PC_W-1:0] p;
      logic [SP_W-1:0] s;
      p = pc_o;
      s = sp_o;
      push();
      run(return_literal_op, 1'b0, 8'h99);
      cmp({work_register_o, carry_o, zero_o}, {8'h99, 1'b0, 1'b0}, "lit work");
      cmp({pc_o, sp_o, busy_o}, {p + 11'h001, s, 1'b1}, "lit pop");
      wait_idle();
   endtask
   task t_ret_int;
      logic [PC_W-1:0] p;
      p = pc_o;
      cmp(global_interrupt_enable_o, 1'b0, "enable off at reset");
      push();
      run(return_interrupt_op, 1'b0, 8'h00);
      cmp({global_interrupt_enable_o, pc_o, sp_o, busy_o}, {1'b1, p + 11'h001, 3'h0, 1'b1}, "int pop");
      @(negedge sys_clk_i);
      cmp(busy_o, 1'b0, "two cycles");
      // Acceptance clears the enable that the return has set
      int_ack_i = 1'b1;
      @(negedge sys_clk_i);
      int_ack_i = 1'b0;
      cmp(global_interrupt_enable_o, 1'b0, "enable off");
   endtask
   // Reset for ten cycles, then walk the scenarios
   initial begin
      repeat (10) @(negedge sys_clk_i);
      nrst_i = 1'b1;
      t_load();
      t_copy();
      t_idle();
      t_rot();
      t_ret_lit();
      t_ret_int();
      finish_test();
   end
endmodule
`default_nettype wire
